// File: design/ea_decode_pkg.sv
// Shared constants and types for the operand and effective-address decoder
package ea_decode_pkg;

  // Effective-address field patterns: upper nibble, low three bits or whole byte
  localparam logic [3:0] EA_REG_DIRECT = 4'hA;
  localparam logic [3:0] EA_PREDEC     = 4'hB;
  localparam logic [3:0] EA_POSTINC    = 4'hC;
  localparam logic [3:0] EA_INDIRECT   = 4'hD;
  localparam logic [3:0] EA_DISP8      = 4'hE;
  localparam logic [3:0] EA_DISP16     = 4'hF;
  localparam logic [3:0] EA_ABS_SHORT  = 4'h0;
  localparam logic [3:0] EA_ABS_LONG   = 4'h1;
  localparam logic [2:0] EA_ABS_LOW    = 3'h5;
  localparam logic [7:0] EA_IMM8       = 8'h04;
  localparam logic [7:0] EA_IMM16      = 8'h0C;

  // Prefix byte taken by the decimal and peripheral-transfer operations
  localparam logic [7:0] PREFIX_BYTE   = 8'h00;

  // Field positions within the effective-address byte
  localparam int SIZE_BIT_POS  = 3;
  localparam int REG_FIELD_LSB = 0;

  // Register number of the stack pointer
  localparam logic [2:0] STACK_POINTER_REG = 3'h7;

  // Reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0]  EXT_RESET  = 2'h0;

  // Decoded addressing modes
  typedef enum logic [3:0] {
    MODE_NONE, MODE_REG_DIRECT, MODE_INDIRECT, MODE_DISP8, MODE_DISP16,
    MODE_PREDEC, MODE_POSTINC, MODE_IMM8, MODE_IMM16,
    MODE_ABS_SHORT, MODE_ABS_LONG, MODE_PC_REL8, MODE_PC_REL16
  } ea_mode_t;

  // Memory access sizes
  typedef enum logic [1:0] {
    ACC_BYTE, ACC_WORD
  } acc_size_t;

endpackage

// File: design/gen_reg_file.sv
// Eight 16-bit general registers with byte-lane write and registered reads
module gen_reg_file (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [2:0]  rd_a_sel,
  output logic      [15:0] rd_a_data,
  input  wire logic [2:0]  rd_b_sel,
  output logic      [15:0] rd_b_data,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_sel,
  input  wire logic        wr_hi_en,
  input  wire logic [15:0] wr_data
);

  logic [15:0] regs [8];

  // Upper lane only written when asked, so byte writes keep it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= ea_decode_pkg::WORD_RESET;
      end
      rd_a_data <= ea_decode_pkg::WORD_RESET;
      rd_b_data <= ea_decode_pkg::WORD_RESET;
    end else begin
      if (wr_en) begin
        regs[wr_sel][7:0] <= wr_data[7:0];
        if (wr_hi_en) begin
          regs[wr_sel][15:8] <= wr_data[15:8];
        end
      end
      rd_a_data <= regs[rd_a_sel];
      rd_b_data <= regs[rd_b_sel];
    end
  end

endmodule

// File: design/operand_ea_decode.sv
// Operand formatting and effective-address decoder for the 16-bit CPU
// Behaviour
// [RQ1] Byte and BCD operands come from register bits 7..0; bits 15..8 ignored.
// [RQ2] Byte or BCD register writes leave the upper eight bits unchanged.
// [RQ3] Longword uses even register for high half, next register for low half.
// [RQ4] BCD byte: bits 7..4 upper digit, bits 3..0 lower digit.
// [RQ5] Word memory access at odd address raises address error, no access.
// [RQ6] Word in memory: high byte at even address, low byte at odd.
// [RQ7] Bit operations on memory fetch byte or word, select bit by number.
// [RQ8] Exception stack saves and restores always use word accesses.
// [RQ9] Pre-decrement or post-increment on stack pointer always word access.
// [RQ10] Stack access with odd stack pointer raises address error.
// [RQ11] General format: EA byte, then extension bytes, then operation code.
// [RQ12] General format takes zero to two extension bytes set by EA byte.
// [RQ13] Decimal and peripheral operations accept a prefix byte before opcode.
// [RQ14] Special format: one or two opcode bytes, then zero to three EA bytes.
// [RQ15] Upper nibble A,D,E,F,B,C select the six register-based modes.
// [RQ16] 00000100 is one-byte immediate, 00001100 two-byte immediate.
// [RQ17] 0000 s 101 short absolute with base register; 0001 s 101 long absolute.
// [RQ18] PC-relative has no EA field; implied by branch opcode, 1 or 2 bytes.
// [RQ19] Size bit clear selects byte operand, set selects word.
// [RQ20] Three-bit register field selects registers 0 to 7 in binary.
// [RQ21] Adjust by one for byte, two for word, always two for stack pointer.
// [RQ22] Undefined EA pattern signals an invalid instruction.
module operand_ea_decode (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Instruction byte stream
  input  wire logic        ibyte_valid,
  input  wire logic [7:0]  ibyte,
  output logic             ibyte_ready,
  input  wire logic        special_fmt,
  input  wire logic        op_two_bytes,
  input  wire logic        op_has_ea,
  input  wire logic        op_pc_rel16,
  input  wire logic        op_pc_rel,
  input  wire logic        prefix_expected,
  input  wire logic [7:0]  short_base_register,
  // Decoded result
  output logic             dec_valid,
  output logic [3:0]       dec_mode,
  output logic             dec_word,
  output logic [2:0]       dec_reg,
  output logic [15:0]      dec_ext,
  output logic [15:0]      dec_opcode,
  output logic             dec_prefixed,
  output logic             dec_invalid,
  input  wire logic        dec_ready,
  // Effective address and operand
  output logic [15:0]      ea_addr,
  output logic [15:0]      reg_adjusted,
  output logic [15:0]      operand,
  output logic [7:0]       bcd_upper_digit,
  output logic [7:0]       bcd_lower_digit,
  // Memory access check
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_word,
  input  wire logic        mem_exc_stack,
  input  wire logic        mem_bit_op,
  input  wire logic [3:0]  mem_bit_num,
  input  wire logic [15:0] mem_rdata,
  output logic             mem_go,
  output logic             mem_word_eff,
  output logic             addr_error,
  output logic             bit_value,
  // Register writeback
  input  wire logic        wb_en,
  input  wire logic [2:0]  wb_reg,
  input  wire logic        wb_word,
  input  wire logic        wb_long,
  input  wire logic [31:0] wb_data,
  output logic [31:0]      long_read
);

  // Byte-stream sequencer states
  typedef enum logic [2:0] {
    ST_OP, ST_EA, ST_EXT, ST_PREFIX, ST_OPC, ST_DONE
  } dec_state_t;

  // All state in one register
  typedef struct packed {
    // Sequencer
    dec_state_t  st;
    logic        op_second;
    logic [1:0]  ext_left;
    // Captured instruction
    logic [15:0] ext;
    logic [15:0] opcode;
    logic [7:0]  ea_byte;
    logic        prefixed;
    logic        invalid;
    logic [3:0]  mode;
    // Longword writeback phase
    logic        long_half;
    // Datapath views
    logic [15:0] operand;
    logic [15:0] ea_addr;
    logic [15:0] adj;
    // Access answers
    logic        addr_err;
    logic        mem_go;
    logic        mem_word;
    logic        bit_val;
  } state_t;

  state_t s_r, s_nxt;

  // Decode one EA byte into a mode and the count of extension bytes
  function automatic logic [5:0] ea_classify(input logic [7:0] b);
    ea_decode_pkg::ea_mode_t m;
    logic [1:0] n;
    m = ea_decode_pkg::MODE_NONE;
    n = 2'h0;
    unique case (b[7:4]) // [RQ15]
      ea_decode_pkg::EA_REG_DIRECT: m = ea_decode_pkg::MODE_REG_DIRECT;
      ea_decode_pkg::EA_INDIRECT:   m = ea_decode_pkg::MODE_INDIRECT;
      ea_decode_pkg::EA_DISP8: begin
        m = ea_decode_pkg::MODE_DISP8;
        n = 2'h1;
      end
      ea_decode_pkg::EA_DISP16: begin
        m = ea_decode_pkg::MODE_DISP16;
        n = 2'h2;
      end
      ea_decode_pkg::EA_PREDEC:     m = ea_decode_pkg::MODE_PREDEC;
      ea_decode_pkg::EA_POSTINC:    m = ea_decode_pkg::MODE_POSTINC;
      ea_decode_pkg::EA_ABS_SHORT: begin
        if (b == ea_decode_pkg::EA_IMM8) begin // [RQ16]
          m = ea_decode_pkg::MODE_IMM8;
          n = 2'h1;
        end else if (b == ea_decode_pkg::EA_IMM16) begin
          m = ea_decode_pkg::MODE_IMM16;
          n = 2'h2;
        end else if (b[2:0] == ea_decode_pkg::EA_ABS_LOW) begin // [RQ17]
          m = ea_decode_pkg::MODE_ABS_SHORT;
          n = 2'h1;
        end
      end
      ea_decode_pkg::EA_ABS_LONG: begin
        if (b[2:0] == ea_decode_pkg::EA_ABS_LOW) begin // [RQ17]
          m = ea_decode_pkg::MODE_ABS_LONG;
          n = 2'h2;
        end
      end
      default: m = ea_decode_pkg::MODE_NONE; // [RQ22]
    endcase
    return {m, n};
  endfunction

  // Step by one or two; stack pointer always two
  function automatic logic [15:0] step_of(input logic word, input logic [2:0] r);
    return (word || r == ea_decode_pkg::STACK_POINTER_REG) ? 16'h0002 : 16'h0001; // [RQ21]
  endfunction

  // Fields of the captured EA byte
  wire logic       sz_bit  = s_r.ea_byte[ea_decode_pkg::SIZE_BIT_POS]; // [RQ19]
  wire logic [2:0] reg_num = s_r.ea_byte[ea_decode_pkg::REG_FIELD_LSB +: 3]; // [RQ20]
  logic [15:0] rf_a, rf_b;
  logic [2:0]  rd_a_sel;
  logic [2:0]  rd_b_sel;
  logic [2:0]  wr_sel;
  logic [15:0] wr_data;
  logic        is_stack_mode;

  // Longword reads come from the pair: A the even register, B its partner
  assign rd_a_sel = wb_long ? {wb_reg[2:1], 1'b0} : reg_num; // [RQ3]
  assign rd_b_sel = wb_long ? {wb_reg[2:1], 1'b1} : reg_num; // [RQ3]
  // Longword writes put the high half in the even register first
  assign wr_sel  = wb_long ? {wb_reg[2:1], s_r.long_half} : wb_reg; // [RQ3]
  assign wr_data = (wb_long && !s_r.long_half) ? wb_data[31:16] : wb_data[15:0];
  // Stack pointer named in an auto step mode
  assign is_stack_mode = (s_r.mode == 4'(ea_decode_pkg::MODE_PREDEC) ||
                          s_r.mode == 4'(ea_decode_pkg::MODE_POSTINC)) &&
                         reg_num == ea_decode_pkg::STACK_POINTER_REG;

  gen_reg_file gen_reg_file_inst (
    .mclk      (mclk),
    .resetn    (resetn),
    .rd_a_sel  (rd_a_sel),
    .rd_a_data (rf_a),
    .rd_b_sel  (rd_b_sel),
    .rd_b_data (rf_b),
    .wr_en     (wb_en),
    .wr_sel    (wr_sel),
    .wr_hi_en  (wb_word | wb_long), // [RQ2]
    .wr_data   (wr_data)
  );

  // Byte-stream sequencer, operand and access checks
  always_comb begin
    logic [5:0] cls;
    logic       word_acc;
    dec_state_t cur_st;
    s_nxt = s_r;
    cls = ea_classify(ibyte);
    // Stack traffic is forced to words whatever the stated size
    word_acc = mem_word | mem_exc_stack | is_stack_mode; // [RQ8] [RQ9]
    // General format has no leading opcode: its first byte is the EA field
    cur_st = (s_r.st == ST_OP && !special_fmt && !op_pc_rel) ? ST_EA : s_r.st; // [RQ11]
    s_nxt.mem_go = 1'b0;
    s_nxt.addr_err = 1'b0;
    // One byte per edge, in the order of the format
    unique case (cur_st)
      ST_OP: if (ibyte_valid) begin // [RQ14]
        s_nxt.opcode = s_r.op_second ? {s_r.opcode[7:0], ibyte} : {8'h00, ibyte};
        s_nxt.ext = ea_decode_pkg::WORD_RESET;
        s_nxt.prefixed = 1'b0;
        if (op_two_bytes && !s_r.op_second) begin
          s_nxt.op_second = 1'b1;
        end else begin
          s_nxt.op_second = 1'b0;
          if (op_pc_rel) begin // [RQ18]
            s_nxt.mode = op_pc_rel16 ? 4'(ea_decode_pkg::MODE_PC_REL16)
                                     : 4'(ea_decode_pkg::MODE_PC_REL8);
            s_nxt.ext_left = op_pc_rel16 ? 2'h2 : 2'h1;
            s_nxt.invalid = 1'b0;
            s_nxt.st = ST_EXT;
          end else begin
            s_nxt.mode = 4'(ea_decode_pkg::MODE_NONE);
            s_nxt.invalid = 1'b0;
            s_nxt.st = op_has_ea ? ST_EA : ST_DONE;
          end
        end
      end
      // EA field: mode, size bit and register number
      ST_EA: if (ibyte_valid) begin // [RQ11]
        // Fresh operand: no stale extension or prefix from the last one
        s_nxt.ext = ea_decode_pkg::WORD_RESET;
        s_nxt.prefixed = 1'b0;
        s_nxt.ea_byte = ibyte;
        s_nxt.mode = cls[5:2];
        s_nxt.ext_left = cls[1:0]; // [RQ12]
        s_nxt.invalid = cls[5:2] == 4'(ea_decode_pkg::MODE_NONE); // [RQ22]
        if (cls[1:0] != 2'h0) begin
          s_nxt.st = ST_EXT;
        end else if (special_fmt) begin
          s_nxt.st = ST_DONE;
        end else begin
          s_nxt.st = prefix_expected ? ST_PREFIX : ST_OPC;
        end
      end
      // Extension or displacement bytes
      ST_EXT: if (ibyte_valid) begin
        s_nxt.ext = {s_r.ext[7:0], ibyte}; // First byte is high
        s_nxt.ext_left = s_r.ext_left - 2'h1;
        if (s_r.ext_left == 2'h1) begin
          if (special_fmt || op_pc_rel) begin
            s_nxt.st = ST_DONE;
          end else begin
            s_nxt.st = prefix_expected ? ST_PREFIX : ST_OPC;
          end
        end
      end
      // Prefix of the decimal and peripheral operations
      ST_PREFIX: if (ibyte_valid) begin // [RQ13]
        s_nxt.prefixed = ibyte == ea_decode_pkg::PREFIX_BYTE;
        s_nxt.invalid = s_r.invalid | (ibyte != ea_decode_pkg::PREFIX_BYTE);
        s_nxt.st = ST_OPC;
      end
      // Trailing opcode of the general format
      ST_OPC: if (ibyte_valid) begin
        s_nxt.opcode = {8'h00, ibyte};
        s_nxt.st = ST_DONE;
      end
      // Result stands until the consumer takes it
      ST_DONE: if (dec_ready) begin
        s_nxt.st = ST_OP;
      end
      default: s_nxt.st = ST_OP;
    endcase

    // Effective address and pre/post adjusted register value
    unique case (s_r.mode)
      4'(ea_decode_pkg::MODE_DISP8):
        s_nxt.ea_addr = rf_b + {{8{s_r.ext[7]}}, s_r.ext[7:0]};
      4'(ea_decode_pkg::MODE_DISP16):  s_nxt.ea_addr = rf_b + s_r.ext;
      4'(ea_decode_pkg::MODE_PREDEC):
        s_nxt.ea_addr = rf_b - step_of(sz_bit, reg_num);
      4'(ea_decode_pkg::MODE_ABS_SHORT):
        s_nxt.ea_addr = {short_base_register, s_r.ext[7:0]}; // [RQ17]
      4'(ea_decode_pkg::MODE_ABS_LONG): s_nxt.ea_addr = s_r.ext;
      default: s_nxt.ea_addr = rf_b;
    endcase
    // Register value after its auto step
    unique case (s_r.mode)
      4'(ea_decode_pkg::MODE_PREDEC):  s_nxt.adj = rf_b - step_of(sz_bit, reg_num); // [RQ21]
      4'(ea_decode_pkg::MODE_POSTINC): s_nxt.adj = rf_b + step_of(sz_bit, reg_num);
      default: s_nxt.adj = rf_b;
    endcase

    // Operand view: byte sizes zero-fill the upper half
    unique case (s_r.mode)
      4'(ea_decode_pkg::MODE_IMM8):  s_nxt.operand = {8'h00, s_r.ext[7:0]};
      4'(ea_decode_pkg::MODE_IMM16): s_nxt.operand = s_r.ext;
      default: s_nxt.operand = sz_bit ? rf_b : {8'h00, rf_b[7:0]}; // [RQ1]
    endcase

    // Alignment check on the forced size; an odd word never goes out
    if (mem_req) begin
      s_nxt.mem_word = word_acc;
      s_nxt.addr_err = word_acc & mem_addr[0]; // [RQ5] [RQ10]
      s_nxt.mem_go = ~(word_acc & mem_addr[0]);
    end
    // Bit test on a fetched operand; high byte sits at the even address
    s_nxt.bit_val = mem_bit_op &
                    (mem_word ? mem_rdata[mem_bit_num] : mem_rdata[mem_bit_num[2:0]]); // [RQ7] [RQ6]

    // Longword writeback alternates high then low half
    s_nxt.long_half = wb_en & wb_long & ~s_r.long_half; // [RQ3]
  end

  // Single state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Handshake and decode result
  assign ibyte_ready     = s_r.st != ST_DONE;
  assign dec_valid       = s_r.st == ST_DONE;
  assign dec_mode        = s_r.mode;
  assign dec_word        = sz_bit;
  assign dec_reg         = reg_num;
  assign dec_ext         = s_r.ext;
  assign dec_opcode      = s_r.opcode;
  assign dec_prefixed    = s_r.prefixed;
  assign dec_invalid     = s_r.invalid;
  assign ea_addr         = s_r.ea_addr;
  assign reg_adjusted    = s_r.adj;
  assign operand         = s_r.operand;
  // BCD digits as seen in the low byte
  assign bcd_upper_digit = {4'h0, s_r.operand[7:4]}; // [RQ4]
  assign bcd_lower_digit = {4'h0, s_r.operand[3:0]};
  // Access answers, one cycle after the request
  assign mem_go          = s_r.mem_go;
  assign mem_word_eff    = s_r.mem_word;
  assign addr_error      = s_r.addr_err;
  assign bit_value       = s_r.bit_val;
  assign long_read       = {rf_a, rf_b}; // [RQ3]

endmodule

// File: tb/ea_stream_model.sv
// Instruction fetch stream model feeding bytes to the decoder
module ea_stream_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [1:0] gap,
  input  wire logic       ibyte_ready,
  output logic            ibyte_valid,
  output logic      [7:0] ibyte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  int         wait_cnt;
  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction
  // Bytes go out in queue order, held until taken; idle line toggles
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ibyte_valid <= 1'b0;
      ibyte       <= 8'hA5;
      wait_cnt    = 0;
    end else begin
      if (ibyte_valid && ibyte_ready) begin
        void'(q.pop_front());
        wait_cnt = gap;
      end
      if (!ibyte_valid || ibyte_ready) begin
        if (wait_cnt == 0 && q.size() > 0) begin
          ibyte_valid <= 1'b1;
          ibyte       <= q[0];
        end else begin
          ibyte_valid <= 1'b0;
          ibyte       <= ~ibyte;
          wait_cnt    = (wait_cnt > 0) ? wait_cnt - 1 : 0;
        end
      end
    end
  end
endmodule

// File: tb/operand_ea_decode_chk.sv
// Port-level assertions for the operand and effective-address decoder
module operand_ea_decode_chk (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ibyte_ready,
  input wire logic        dec_valid,
  input wire logic [3:0]  dec_mode,
  input wire logic [2:0]  dec_reg,
  input wire logic        dec_invalid,
  input wire logic        dec_ready,
  input wire logic        mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_word,
  input wire logic        mem_exc_stack,
  input wire logic        mem_bit_op,
  input wire logic [3:0]  mem_bit_num,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_go,
  input wire logic        mem_word_eff,
  input wire logic        addr_error,
  input wire logic        bit_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bit_exp_r;
  logic sp_mode;
  // Bit chosen at request time, so a late operand change cannot hide a slip
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_exp_r <= 1'b0;
    end else begin
      bit_exp_r <= mem_rdata[mem_bit_num];
    end
  end
  // Stack pointer named in a pre-decrement or post-increment decode
  assign sp_mode = dec_reg == 3'h7 && (dec_mode == ea_decode_pkg::MODE_PREDEC ||
                                       dec_mode == ea_decode_pkg::MODE_POSTINC);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_ODD_WORD: assert property (mem_req && mem_word && mem_addr[0] |=> addr_error && !mem_go)
    else $error("odd word access went ahead");
  AST_EVEN_GO: assert property (mem_req && !mem_addr[0] |=> mem_go && !addr_error)
    else $error("even access not granted");
  AST_NO_SPONT: assert property (!mem_req |=> !mem_go && !addr_error)
    else $error("access answer without request");
  AST_EXC_WORD: assert property (mem_req && mem_exc_stack |=> mem_word_eff)
    else $error("exception stack access not word sized");
  AST_EXC_ODD: assert property (mem_req && mem_exc_stack && mem_addr[0] |=> addr_error)
    else $error("odd stack pointer not flagged");
  AST_SP_WORD: assert property (mem_req && dec_valid && sp_mode |=> mem_word_eff)
    else $error("stack pointer auto mode not word sized");
  AST_BIT_SEL: assert property (mem_req && mem_bit_op |=> bit_value == bit_exp_r)
    else $error("wrong bit selected");
  AST_DEC_HOLD: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_mode))
    else $error("decode result dropped before taken");
  AST_INVALID: assert property (dec_valid && dec_invalid |-> dec_mode == ea_decode_pkg::MODE_NONE)
    else $error("invalid decode carries a mode");
  AST_DONE_REFUSE: assert property (dec_valid |-> !ibyte_ready)
    else $error("byte accepted while result pending");
  AST_RELEASE: assert property (dec_valid && dec_ready |=> !dec_valid)
    else $error("result not released");
  // Main scenarios reached
  cover property (mem_req && mem_addr[0] ##1 addr_error);
  cover property (dec_valid && dec_invalid);
  cover property (dec_valid && sp_mode && mem_req);
endmodule

// File: tb/operand_ea_decode_tb.sv
// Self-checking bench for the operand and effective-address decoder
module operand_ea_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]              ea;
    int                      n;
    logic [15:0]             ext;
    ea_decode_pkg::ea_mode_t mode;
  } row_t;
  logic        mclk, resetn, special_fmt, op_two_bytes, op_has_ea, op_pc_rel16, op_pc_rel;
  logic        prefix_expected, dec_ready, mem_req, mem_word, mem_exc_stack, mem_bit_op;
  logic        wb_en, wb_word, wb_long, ibyte_valid, ibyte_ready, dec_valid, dec_word;
  logic        dec_prefixed, dec_invalid, mem_go, mem_word_eff, addr_error, bit_value;
  logic [1:0]  stall;
  logic [2:0]  dec_reg, wb_reg;
  logic [3:0]  dec_mode, mem_bit_num;
  logic [7:0]  ibyte, short_base_register, bcd_upper_digit, bcd_lower_digit;
  logic [15:0] dec_ext, dec_opcode, ea_addr, reg_adjusted, operand, mem_addr, mem_rdata;
  logic [31:0] wb_data, long_read;
  int          error_cnt, compares, cyc;
  row_t        rows[11];

  operand_ea_decode operand_ea_decode_inst (.mclk, .resetn, .ibyte_valid, .ibyte,
    .ibyte_ready, .special_fmt, .op_two_bytes, .op_has_ea, .op_pc_rel16, .op_pc_rel,
    .prefix_expected, .short_base_register, .dec_valid, .dec_mode, .dec_word, .dec_reg,
    .dec_ext, .dec_opcode, .dec_prefixed, .dec_invalid, .dec_ready, .ea_addr, .reg_adjusted,
    .operand, .bcd_upper_digit, .bcd_lower_digit, .mem_req, .mem_addr, .mem_word,
    .mem_exc_stack, .mem_bit_op, .mem_bit_num, .mem_rdata, .mem_go, .mem_word_eff,
    .addr_error, .bit_value, .wb_en, .wb_reg, .wb_word, .wb_long, .wb_data, .long_read);
  ea_stream_model ea_stream_model_inst (.mclk, .resetn, .gap(stall), .ibyte_ready,
    .ibyte_valid, .ibyte);

  // Free-running clock and a hang guard well past the expected run length
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [7:0] b);
    ea_stream_model_inst.push(b);
  endtask
  // Waits at falling edges, then lets registered outputs settle
  task automatic wait_dec();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (dec_valid !== 1'b1 && k < 60);
    chk(dec_valid, 1);
    repeat (3) @(negedge mclk);
  endtask
  task automatic rel();
    @(posedge mclk);
    dec_ready <= 1'b1;
    @(posedge mclk);
    dec_ready <= 1'b0;
  endtask
  // Register direct style decode: EA byte then opcode, result left pending
  task automatic rd(input logic [7:0] ea);
    push(ea);
    push(8'h3C);
    wait_dec();
  endtask
  task automatic wb(input logic [2:0] r, input logic w, input logic l, input logic [31:0] d);
    @(posedge mclk);
    wb_en   <= 1'b1;
    wb_reg  <= r;
    wb_word <= w;
    wb_long <= l;
    wb_data <= d;
    @(posedge mclk);
    if (l) @(posedge mclk);
    wb_en <= 1'b0;
  endtask
  // One access check; read data is the inverted address, so the bit varies
  task automatic mchk(input logic [15:0] a, input logic w, input logic e,
                      input logic [3:0] bn, input logic go, input logic we);
    @(posedge mclk);
    mem_req       <= 1'b1;
    mem_addr      <= a;
    mem_word      <= w;
    mem_exc_stack <= e;
    mem_bit_num   <= bn;
    mem_rdata     <= ~a;
    @(posedge mclk);
    mem_req <= 1'b0;
    @(negedge mclk);
    chk(mem_go, go);
    chk(addr_error, !go);
    chk(mem_word_eff, we);
    chk(bit_value, !a[bn]);
  endtask
  task automatic wrap_up();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {mclk, resetn, special_fmt, op_two_bytes, op_has_ea, op_pc_rel16, op_pc_rel} = '0;
    {prefix_expected, dec_ready, mem_req, mem_word, mem_exc_stack, wb_en, wb_word} = '0;
    {wb_long, stall, wb_reg, mem_bit_num, mem_addr, mem_rdata, wb_data} = '0;
    {error_cnt, compares, cyc} = '0;
    mem_bit_op          = 1'b1;
    short_base_register = 8'h9C;
    rows = '{'{8'hA9, 0, 16'h0000, ea_decode_pkg::MODE_REG_DIRECT},
             '{8'hD0, 0, 16'h0000, ea_decode_pkg::MODE_INDIRECT},
             '{8'hE3, 1, 16'h007F, ea_decode_pkg::MODE_DISP8},
             '{8'hFE, 2, 16'h1234, ea_decode_pkg::MODE_DISP16},
             '{8'hB5, 0, 16'h0000, ea_decode_pkg::MODE_PREDEC},
             '{8'hCF, 0, 16'h0000, ea_decode_pkg::MODE_POSTINC},
             '{8'h04, 1, 16'h0055, ea_decode_pkg::MODE_IMM8},
             '{8'h0C, 2, 16'hBEEF, ea_decode_pkg::MODE_IMM16},
             '{8'h0D, 1, 16'h0040, ea_decode_pkg::MODE_ABS_SHORT},
             '{8'h15, 2, 16'h8000, ea_decode_pkg::MODE_ABS_LONG},
             '{8'h20, 0, 16'h0000, ea_decode_pkg::MODE_NONE}};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk(ibyte_ready, 1);
    chk(dec_valid, 0);
    // Every mode encoding, prompt and stalled stream in turn
    foreach (rows[i]) begin
      @(posedge mclk);
      stall <= i[0] ? 2'h2 : 2'h0;
      push(rows[i].ea);
      if (rows[i].n == 2) push(rows[i].ext[15:8]);
      if (rows[i].n > 0) push(rows[i].ext[7:0]);
      push(8'h3C);
      wait_dec();
      chk(dec_mode, rows[i].mode);
      chk(dec_word, rows[i].ea[3]);
      if (rows[i].ea[7:4] > 4'h9) chk(dec_reg, rows[i].ea[2:0]);
      chk(dec_invalid, rows[i].mode == ea_decode_pkg::MODE_NONE);
      if (rows[i].n == 2) chk(dec_ext, rows[i].ext);
      if (rows[i].n == 1) chk(dec_ext[7:0], rows[i].ext[7:0]);
      rel();
    end
    mchk(16'h1000, 1'b1, 1'b0, 4'hC, 1'b1, 1'b1);
    mchk(16'h1001, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1);
    mchk(16'h1001, 1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
    mchk(16'h2002, 1'b0, 1'b1, 4'hF, 1'b1, 1'b1);
    mchk(16'h2003, 1'b0, 1'b1, 4'h1, 1'b0, 1'b1);
    // Byte write keeps the high byte; byte read and digits from the low byte
    wb(3'h2, 1'b1, 1'b0, 32'h0000_1234);
    wb(3'h2, 1'b0, 1'b0, 32'h0000_5AAB);
    rd(8'hAA);
    chk(operand, 16'h12AB);
    rel();
    rd(8'hA2);
    chk(operand[7:0], 8'hAB);
    chk(bcd_upper_digit[3:0], 4'hA);
    chk(bcd_lower_digit[3:0], 4'hB);
    rel();
    wb(3'h4, 1'b1, 1'b1, 32'hDEAD_BEEF);
    repeat (2) @(negedge mclk);
    chk(long_read, 32'hDEAD_BEEF);
    @(posedge mclk);
    wb_long <= 1'b0;
    rd(8'hAC);
    chk(operand, 16'hDEAD);
    rel();
    rd(8'hAD);
    chk(operand, 16'hBEEF);
    rel();
    // Auto adjust by size, forced to two on the stack pointer
    rd(8'hBC);
    chk(reg_adjusted, 16'hDEAB);
    rel();
    rd(8'hB4);
    chk(reg_adjusted, 16'hDEAC);
    rel();
    wb(3'h7, 1'b1, 1'b0, 32'h0000_0101);
    rd(8'hB7);
    chk(reg_adjusted, 16'h00FF);
    mchk(16'h0101, 1'b0, 1'b0, 4'h8, 1'b0, 1'b1);
    rel();
    rd(8'hC7);
    chk(reg_adjusted, 16'h0103);
    rel();
    push(8'h05);
    rd(8'h40);
    chk(ea_addr, 16'h9C40);
    rel();
    prefix_expected <= 1'b1;
    push(8'hA0);
    rd(8'h00);
    chk(dec_prefixed, 1);
    chk(dec_opcode[7:0], 8'h3C);
    rel();
    {prefix_expected, special_fmt, op_two_bytes, op_has_ea} <= 4'h7;
    push(8'h11);
    push(8'h22);
    push(8'hD1);
    wait_dec();
    chk(dec_mode, ea_decode_pkg::MODE_INDIRECT);
    chk(dec_opcode, 16'h1122);
    rel();
    {op_two_bytes, op_has_ea, op_pc_rel, op_pc_rel16} <= 4'h3;
    push(8'h20);
    push(8'h01);
    push(8'h02);
    wait_dec();
    chk(dec_mode, ea_decode_pkg::MODE_PC_REL16);
    chk(dec_ext, 16'h0102);
    rel();
    op_pc_rel16 <= 1'b0;
    push(8'h20);
    push(8'h7E);
    wait_dec();
    chk(dec_mode, ea_decode_pkg::MODE_PC_REL8);
    rel();
    wrap_up();
  end
endmodule

bind operand_ea_decode operand_ea_decode_chk operand_ea_decode_chk_inst (.mclk, .resetn,
  .ibyte_ready, .dec_valid, .dec_mode, .dec_reg, .dec_invalid, .dec_ready, .mem_req,
  .mem_addr, .mem_word, .mem_exc_stack, .mem_bit_op, .mem_bit_num, .mem_rdata, .mem_go,
  .mem_word_eff, .addr_error, .bit_value);
